// ==== ccde_core.sv ====
// Purpose: Executes call, clear-working, watchdog-clear and decrement-file instructions.
// Assumes: Instructions arrive from logic on i_ref_clk; registers reached over a plain port.
// Notes: Unknown instructions only advance the program counter and pulse o_unsupported.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
module ccde_core (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [13:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_busy,
    output logic o_unsupported,
    output logic [12:0] o_pc,
    output logic [7:0] o_w,
    output logic [7:0] o_status,
    output logic [12:0] o_stack_top,
    output logic [7:0] o_watchdog_counter
);

    // ************************************************************
    // State
    // ************************************************************
    logic [12:0] pc_reg, pc_next;
    logic [7:0] w_reg, w_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] pch_reg, pch_next;
    logic [7:0] wdog_reg, wdog_next;
    logic [7:0] prescale_reg, prescale_next;
    // The stack pointer wraps silently after eight pushes.
    logic [2:0] sp_reg, sp_next;
    logic busy_reg, busy_next;
    logic unsup_reg, unsup_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [12:0] stack_mem [ccde_pkg::STACK_DEPTH];
    logic [7:0] file_mem [ccde_pkg::FILE_DEPTH];
    logic stack_we;
    logic [2:0] stack_wa;
    logic [12:0] stack_wd;
    logic file_we;
    logic [6:0] file_wa;
    logic [7:0] file_wd;
    logic [7:0] file_rd;
    logic [7:0] dec_res;
    logic take;

    // ************************************************************
    // Decoder
    // ************************************************************
    ccde_dec_if dec_bus ();

    ccde_decode u_decode (
        .bus(dec_bus)
    );

    assign dec_bus.instr = i_instr;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Program counter arithmetic wraps at thirteen bits.
    function automatic logic [12:0] pc_inc(input logic [12:0] pc);
        pc_inc = pc + 13'h0001;
    endfunction

    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        pc_next = pc_reg;
        w_next = w_reg;
        status_next = status_reg;
        pch_next = pch_reg;
        sp_next = sp_reg;
        busy_next = 1'b0;
        unsup_next = 1'b0;
        rdata_next = 8'h00;
        stack_we = 1'b0;
        stack_wa = sp_reg;
        stack_wd = pc_reg;
        file_we = 1'b0;
        file_wa = i_addr[6:0];
        file_wd = i_wdata;
        file_rd = file_mem[dec_bus.faddr];
        dec_res = file_rd - 8'h01;
        take = i_instr_valid && !busy_reg;

        // The prescaler runs every cycle and carries into the watchdog counter.
        prescale_next = prescale_reg + 8'h01;
        wdog_next = wdog_reg;
        if (prescale_reg == ccde_pkg::PRESCALE_FULL)
        begin
            wdog_next = wdog_reg + 8'h01;
        end

        // Software writes come first so that an instruction in the same cycle wins.
        if (i_wr)
        begin
            if (i_addr[ccde_pkg::FILE_SEL_BIT])
            begin
                file_we = 1'b1;
            end
            else
            begin
                case (i_addr)
                    ccde_pkg::ADDR_W: w_next = i_wdata;
                    ccde_pkg::ADDR_STATUS: status_next = i_wdata;
                    ccde_pkg::ADDR_PCH_LATCH: pch_next = i_wdata;
                    ccde_pkg::ADDR_PC_LO: pc_next = {pc_reg[12:8], i_wdata};
                    ccde_pkg::ADDR_PC_HI: pc_next = {i_wdata[4:0], pc_reg[7:0]};
                    default: ;
                endcase
            end
        end

        // A word offered in the second call cycle is dropped, not queued.
        if (take)
        begin
            case (dec_bus.op)
                ccde_pkg::OP_CALL:
                begin
                    // The pc holds during the second call cycle.
                    stack_we = 1'b1;
                    stack_wd = pc_inc(pc_reg);
                    sp_next = sp_reg + 3'h1;
                    pc_next = {pch_reg[ccde_pkg::PCH_HI_BIT:ccde_pkg::PCH_LO_BIT],
                               dec_bus.imm};
                    busy_next = 1'b1;
                end
                ccde_pkg::OP_CLEAR_WORK:
                begin
                    w_next = ccde_pkg::W_RESET;
                    status_next[ccde_pkg::STATUS_Z_BIT] = 1'b1;
                    pc_next = pc_inc(pc_reg);
                end
                ccde_pkg::OP_WDOG_CLEAR:
                begin
                    wdog_next = ccde_pkg::WDOG_CLEAR;
                    prescale_next = ccde_pkg::PRESCALE_CLEAR;
                    status_next[ccde_pkg::STATUS_TMOUT_BIT] = 1'b1;
                    status_next[ccde_pkg::STATUS_PWRDN_BIT] = 1'b1;
                    pc_next = pc_inc(pc_reg);
                end
                ccde_pkg::OP_DEC_FILE:
                begin
                    // The zero flag follows the result for either destination.
                    status_next[ccde_pkg::STATUS_Z_BIT] = is_zero(dec_res);
                    if (dec_bus.dest)
                    begin
                        file_we = 1'b1;
                        file_wa = dec_bus.faddr;
                        file_wd = dec_res;
                    end
                    else
                    begin
                        w_next = dec_res;
                    end
                    pc_next = pc_inc(pc_reg);
                end
                default:
                begin
                    // Unknown words only step the pc and raise a one-cycle flag.
                    unsup_next = 1'b1;
                    pc_next = pc_inc(pc_reg);
                end
            endcase
        end

        // Read data stand for one cycle only and read zero otherwise.
        if (i_rd)
        begin
            if (i_addr[ccde_pkg::FILE_SEL_BIT])
            begin
                rdata_next = file_mem[i_addr[6:0]];
            end
            else
            begin
                case (i_addr)
                    ccde_pkg::ADDR_W: rdata_next = w_reg;
                    ccde_pkg::ADDR_STATUS: rdata_next = status_reg;
                    ccde_pkg::ADDR_PCH_LATCH: rdata_next = pch_reg;
                    ccde_pkg::ADDR_PC_LO: rdata_next = pc_reg[7:0];
                    ccde_pkg::ADDR_PC_HI: rdata_next = {3'h0, pc_reg[12:8]};
                    ccde_pkg::ADDR_WDOG: rdata_next = wdog_reg;
                    ccde_pkg::ADDR_PRESCALE: rdata_next = prescale_reg;
                    ccde_pkg::ADDR_STACK_LO: rdata_next = stack_mem[sp_reg - 3'h1][7:0];
                    ccde_pkg::ADDR_STACK_HI:
                        rdata_next = {3'h0, stack_mem[sp_reg - 3'h1][12:8]};
                    default: rdata_next = 8'h00;
                endcase
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pc_reg <= ccde_pkg::PC_RESET;
            w_reg <= ccde_pkg::W_RESET;
            status_reg <= ccde_pkg::STATUS_RESET;
            pch_reg <= ccde_pkg::PCH_RESET;
            wdog_reg <= ccde_pkg::WDOG_CLEAR;
            prescale_reg <= ccde_pkg::PRESCALE_CLEAR;
            sp_reg <= 3'h0;
            busy_reg <= 1'b0;
            unsup_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            pc_reg <= pc_next;
            w_reg <= w_next;
            status_reg <= status_next;
            pch_reg <= pch_next;
            wdog_reg <= wdog_next;
            prescale_reg <= prescale_next;
            sp_reg <= sp_next;
            busy_reg <= busy_next;
            unsup_reg <= unsup_next;
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // Storage arrays
    // ************************************************************
    // Storage arrays have no reset; software initialises the file registers.
    // The file array has one write port shared by software and instructions.
    always_ff @(posedge i_ref_clk)
    begin
        if (stack_we)
        begin
            stack_mem[stack_wa] <= stack_wd;
        end
        if (file_we)
        begin
            file_mem[file_wa] <= file_wd;
        end
    end

    // ************************************************************
    // Stack top copy
    // ************************************************************
    // The stack top copy is a flop so the output needs no array read path.
    logic [12:0] stack_top_reg, stack_top_next;

    always_comb
    begin
        stack_top_next = stack_top_reg;
        if (stack_we)
        begin
            stack_top_next = stack_wd;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stack_top_reg <= ccde_pkg::PC_RESET;
        end
        else
        begin
            stack_top_reg <= stack_top_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_rdata = rdata_reg;
    assign o_busy = busy_reg;
    assign o_unsupported = unsup_reg;
    assign o_pc = pc_reg;
    assign o_w = w_reg;
    assign o_status = status_reg;
    assign o_stack_top = stack_top_reg;
    assign o_watchdog_counter = wdog_reg;

endmodule

// ==== ccde_core_asserts.sv ====
// Purpose: Checks instruction effects of ccde_core at its ports.
// Assumes: One clock; no bus write shares a cycle with a checked instruction.
// Notes: The pc high latch bits are mirrored from bus writes.
`timescale 1ns/100ps
module ccde_core_asserts (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [13:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic o_busy,
    input wire logic [12:0] o_pc,
    input wire logic [7:0] o_w,
    input wire logic [7:0] o_status,
    input wire logic [12:0] o_stack_top,
    input wire logic [7:0] o_watchdog_counter
);
    logic take;
    logic is_call;
    logic is_clear_work;
    logic is_wdog_clear;
    logic is_dec_file;
    logic is_dec_to_w;
    logic is_dec_to_file;
    logic [1:0] latch_reg;
    logic [1:0] latch_next;

    assign take = i_instr_valid && !o_busy;
    assign is_call = take && ((i_instr & ccde_pkg::CALL_MASK) == ccde_pkg::CALL_MATCH);
    assign is_clear_work = take && (i_instr == ccde_pkg::CLR_WORK_CODE);
    assign is_wdog_clear = take && (i_instr == ccde_pkg::WDOG_CLR_CODE);
    assign is_dec_file = take
        && ((i_instr & ccde_pkg::DEC_FILE_MASK) == ccde_pkg::DEC_FILE_MATCH);
    assign is_dec_to_w = is_dec_file && !i_instr[ccde_pkg::DEST_BIT];
    assign is_dec_to_file = is_dec_file && i_instr[ccde_pkg::DEST_BIT];
    assign latch_next = (i_wr && i_addr == ccde_pkg::ADDR_PCH_LATCH) ? i_wdata[4:3] : latch_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            latch_reg <= 2'b00;
        end
        else
        begin
            latch_reg <= latch_next;
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_call;
        is_call;
    endsequence

    sequence s_busy_pulse;
        o_busy ##1 !o_busy;
    endsequence

    sequence s_flags_kept;
        o_status == $past(o_status);
    endsequence

    sequence s_pc_step;
        !o_busy && o_pc == $past(o_pc) + 13'h0001;
    endsequence

    a_call_push: assert property (s_call |=> o_stack_top == $past(o_pc) + 13'h0001)
        else $error("Call pushed a wrong return address.");
    a_call_imm: assert property (s_call |=> o_pc[10:0] == $past(i_instr[10:0]))
        else $error("Call loaded a wrong low pc.");
    a_call_high: assert property (s_call |=> o_pc[12:11] == $past(latch_reg))
        else $error("Call loaded a wrong high pc.");
    a_call_two_cycle: assert property (s_call |=> s_flags_kept ##0 s_busy_pulse)
        else $error("Call length or status wrong.");
    a_clear_work: assert property (is_clear_work |=> o_w == 8'h00 && o_status[2])
        else $error("Clear working result wrong.");
    a_wdog_zero: assert property (is_wdog_clear |=> o_watchdog_counter == 8'h00)
        else $error("Watchdog clear left the counter running.");
    a_wdog_flags: assert property (is_wdog_clear |=> o_status[4:3] == 2'b11)
        else $error("Watchdog clear left a status flag low.");
    a_dec_zero: assert property (is_dec_to_w |=> o_status[2] == (o_w == 8'h00))
        else $error("Decrement zero flag wrong.");
    a_dec_dest: assert property (is_dec_to_file |=> $stable(o_w))
        else $error("Decrement to file changed working.");
    a_one_cycle: assert property (take && !is_call |=> s_pc_step)
        else $error("Single cycle instruction took longer.");
endmodule

bind ccde_core ccde_core_asserts u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_busy(o_busy), .o_pc(o_pc),
    .o_w(o_w), .o_status(o_status), .o_stack_top(o_stack_top),
    .o_watchdog_counter(o_watchdog_counter)
);

// ==== ccde_core_tb.sv ====
// Purpose: Self-checking bench for the execute block.
// Assumes: Reset held 10 cycles; bus accesses and instructions never share a cycle.
// Notes: File register 127 sits at port address 0xff.
`timescale 1ns/100ps
module ccde_core_tb;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [13:0] i_instr = 14'h0000;
    logic i_instr_valid = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic o_busy;
    logic o_unsupported;
    logic [12:0] o_pc;
    logic [7:0] o_w;
    logic [7:0] o_status;
    logic [12:0] o_stack_top;
    logic [7:0] o_watchdog_counter;
    logic [7:0] v;
    logic [7:0] st;
    int error_cnt = 0;
    int tests_run = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    ccde_core uut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_busy(o_busy), .o_unsupported(o_unsupported), .o_pc(o_pc), .o_w(o_w),
        .o_status(o_status), .o_stack_top(o_stack_top), .o_watchdog_counter(o_watchdog_counter)
    );

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic ex(input logic [13:0] ins);
        @(posedge i_ref_clk);
        i_instr <= ins;
        i_instr_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b0;
        #1;
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial
    begin
        #20000;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        #1;
        chk(o_pc, 16'h0000);
        chk(o_status, ccde_pkg::STATUS_RESET);
        chk(o_busy, 16'h0000);
        wr(8'h10, 8'h5a);
        rd(8'h10, v);
        chk(v, 16'h0000);
        wr(ccde_pkg::ADDR_W, 8'h5a);
        ex(ccde_pkg::CLR_WORK_CODE);
        chk(o_w, 16'h0000);
        chk(o_status[2], 16'h0001);
        chk(o_pc, 16'h0001);
        chk(o_unsupported, 16'h0000);
        wr(8'hff, 8'h02);
        ex(14'h037f);
        chk(o_w, 16'h0001);
        chk(o_status[2], 16'h0000);
        rd(8'hff, v);
        chk(v, 16'h0002);
        ex(14'h03ff);
        ex(14'h03ff);
        chk(o_status[2], 16'h0001);
        chk(o_w, 16'h0001);
        ex(14'h03ff);
        chk(o_status[2], 16'h0000);
        chk(o_pc, 16'h0005);
        rd(8'hff, v);
        chk(v, 16'h00ff);
        wr(ccde_pkg::ADDR_STATUS, 8'h00);
        repeat (300) @(posedge i_ref_clk);
        chk(o_watchdog_counter != 8'h00, 16'h0001);
        ex(ccde_pkg::WDOG_CLR_CODE);
        chk(o_watchdog_counter, 16'h0000);
        chk(o_status[4:3], 16'h0003);
        rd(ccde_pkg::ADDR_PRESCALE, v);
        chk(v, 16'h0001);
        wr(ccde_pkg::ADDR_PCH_LATCH, 8'h18);
        st = o_status;
        @(posedge i_ref_clk);
        i_instr <= 14'h27ff;
        i_instr_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_instr <= ccde_pkg::CLR_WORK_CODE;
        #1;
        chk(o_pc, 16'h1fff);
        chk(o_stack_top, 16'h0007);
        chk(o_busy, 16'h0001);
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b0;
        #1;
        chk(o_busy, 16'h0000);
        chk(o_pc, 16'h1fff);
        chk(o_status, st);
        chk(o_w, 16'h0001);
        wr(ccde_pkg::ADDR_PCH_LATCH, 8'h08);
        ex(14'h2000);
        chk(o_pc, 16'h0800);
        chk(o_stack_top, 16'h0000);
        ex(14'h0000);
        chk(o_unsupported, 16'h0001);
        chk(o_pc, 16'h0801);
        end_of_test();
    end
endmodule

// ==== ccde_dec_if.sv ====
// Purpose: Carries an instruction word to the decoder and the decoded fields back.
// Assumes: Purely combinational path inside one clock domain.
// Notes: None.
`timescale 1ns/100ps
interface ccde_dec_if;
    logic [13:0] instr;
    ccde_pkg::ccde_op_e op;
    logic [10:0] imm;
    logic [6:0] faddr;
    logic dest;
    modport dec (input instr, output op, imm, faddr, dest);
    modport core (output instr, input op, imm, faddr, dest);
endinterface

// ==== ccde_decode.sv ====
// Purpose: Decodes the four executed instructions and extracts their operands.
// Assumes: Instruction word is stable while decoded.
// Notes: Any other word decodes to OP_NONE.
`timescale 1ns/100ps
module ccde_decode (
    ccde_dec_if.dec bus
);
    always_comb
    begin
        bus.imm = bus.instr[10:0];
        bus.faddr = bus.instr[6:0];
        bus.dest = bus.instr[ccde_pkg::DEST_BIT];
        if ((bus.instr & ccde_pkg::CALL_MASK) == ccde_pkg::CALL_MATCH)
        begin
            bus.op = ccde_pkg::OP_CALL;
        end
        else if (bus.instr == ccde_pkg::CLR_WORK_CODE)
        begin
            bus.op = ccde_pkg::OP_CLEAR_WORK;
        end
        else if (bus.instr == ccde_pkg::WDOG_CLR_CODE)
        begin
            bus.op = ccde_pkg::OP_WDOG_CLEAR;
        end
        else if ((bus.instr & ccde_pkg::DEC_FILE_MASK) == ccde_pkg::DEC_FILE_MATCH)
        begin
            bus.op = ccde_pkg::OP_DEC_FILE;
        end
        else
        begin
            bus.op = ccde_pkg::OP_NONE;
        end
    end
endmodule

// ==== ccde_pkg.sv ====
// Purpose: Shared constants and types of the call/clear/decrement execute block.
// Assumes: One instruction clock; 14-bit instruction words; 8-bit data path.
// Notes: Register offsets are byte indices on the plain register port.
package ccde_pkg;

    // ************************************************************
    // Instruction encodings
    // ************************************************************
    localparam logic [13:0] CALL_MASK = 14'h3800;
    localparam logic [13:0] CALL_MATCH = 14'h2000;
    localparam logic [13:0] CLR_WORK_CODE = 14'h0103;
    localparam logic [13:0] WDOG_CLR_CODE = 14'h0064;
    localparam logic [13:0] DEC_FILE_MASK = 14'h3f00;
    localparam logic [13:0] DEC_FILE_MATCH = 14'h0300;
    localparam int DEST_BIT = 7;

    // ************************************************************
    // Widths and sizes
    // ************************************************************
    localparam int PC_W = 13;
    localparam int IMM_W = 11;
    localparam int FADDR_W = 7;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int FILE_DEPTH = 128;

    // ************************************************************
    // Register port map
    // ************************************************************
    localparam logic [7:0] ADDR_W = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_PCH_LATCH = 8'h02;
    localparam logic [7:0] ADDR_PC_LO = 8'h03;
    localparam logic [7:0] ADDR_PC_HI = 8'h04;
    localparam logic [7:0] ADDR_WDOG = 8'h05;
    localparam logic [7:0] ADDR_PRESCALE = 8'h06;
    localparam logic [7:0] ADDR_STACK_LO = 8'h07;
    localparam logic [7:0] ADDR_STACK_HI = 8'h08;
    localparam int FILE_SEL_BIT = 7;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int STATUS_Z_BIT = 2;
    localparam int STATUS_PWRDN_BIT = 3;
    localparam int STATUS_TMOUT_BIT = 4;
    localparam int PCH_LO_BIT = 3;
    localparam int PCH_HI_BIT = 4;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [7:0] PCH_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;
    localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
    localparam logic [7:0] PRESCALE_FULL = 8'hff;

    typedef enum {
        OP_NONE,
        OP_CALL,
        OP_CLEAR_WORK,
        OP_WDOG_CLEAR,
        OP_DEC_FILE
    } ccde_op_e;

endpackage
